// ### core/bkrc_regfile.sv
// APB register bank for the second buck converter and the third buck run voltage.
// Assumes an APB master on the same clock and static fuse pins; mode pins may change and are synchronised.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "bkrc_regs.svh"
module bkrc_regfile
    import bkrc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fuse and mode pins
    input wire logic [15:0] fusePins,
    input wire logic [1:0] powerModePins,
    // Converter controls
    output logic buckTwoOn,
    output logic lowPowerActive,
    output logic [5:0] targetVoltageCode,
    output logic slewSlow,
    output logic forcedPwmWhileScaling,
    output logic forcedPwm,
    output logic dischargeConnect,
    output logic [1:0] currentLimitCode,
    output logic toffControl,
    output logic [3:0] thirdRunVoltageCode
);
    bkrc_fuse_t fuseWord;
    logic loadPulse;
    logic loadDone;
    logic [1:0] modeMeta_r;
    logic [1:0] modeSync_r;
    bkrc_mode_t mode;
    logic [5:0] runVolt_r;
    logic [5:0] sleepVolt_r;
    logic [7:0] control_r;
    logic [1:0] limit_r;
    logic tmode_r;
    logic [3:0] thirdVolt_r;
    logic schemeSel_r;
    logic [31:0] readData;
    logic readMapped;
    logic apbSetup;
    logic apbWrite;
    logic [7:0] index;

    // Index from byte address, word aligned
    function automatic logic [7:0] addrIndex(input logic [9:0] addr);
        addrIndex = addr[9:2];
    endfunction : addrIndex

    // Known register index
    function automatic logic isMapped(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        isMapped = (addr[1:0] == 2'h0) && (idx == `BKRC_IDX_RUN_VOLT ||
            idx == `BKRC_IDX_SLEEP_VOLT || idx == `BKRC_IDX_CONTROL ||
            idx == `BKRC_IDX_LIMIT || idx == `BKRC_IDX_THIRD_VOLT ||
            idx == `BKRC_IDX_STATUS);
    endfunction : isMapped

    // Fuse capture and start-up load
    bkrc_fuse_loader loader (
        .clock(clock),
        .reset_n(reset_n),
        .fusePins(fusePins),
        .fuseWord(fuseWord),
        .loadPulse(loadPulse),
        .loadDone(loadDone)
    );

    // Two-flop synchroniser on the mode pins
    always_ff @(posedge clock) begin
        modeMeta_r <= powerModePins;
        modeSync_r <= modeMeta_r;
    end

    assign mode = bkrc_mode_t'(modeSync_r);

    // APB decode
    assign index = addrIndex(paddr);
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && isMapped(paddr);
    assign pready = psel && penable;

    // Run voltage code, fuse-backed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            runVolt_r <= `BKRC_RST_VOLT6;
        end else if (loadPulse) begin
            runVolt_r <= fuseWord.runVolt;
        end else if (apbWrite && index == `BKRC_IDX_RUN_VOLT) begin
            runVolt_r <= pwdata[5:0];
        end
    end

    // Sleep voltage code, loaded from the run code fuses
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sleepVolt_r <= `BKRC_RST_VOLT6;
        end else if (loadPulse) begin
            sleepVolt_r <= fuseWord.runVolt;
        end else if (apbWrite && index == `BKRC_IDX_SLEEP_VOLT) begin
            sleepVolt_r <= pwdata[5:0];
        end
    end

    // Control register; sleep enable and mode bits have no fuse
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            control_r <= `BKRC_RST_CONTROL;
        end else if (loadPulse) begin
            control_r[`BKRC_CTL_RUN_EN] <= fuseWord.runEnable;
            control_r[`BKRC_CTL_STBY_EN] <= fuseWord.runEnable;
            control_r[`BKRC_CTL_SLEW] <= fuseWord.slewSelect;
            control_r[`BKRC_CTL_DIS_OFF] <= fuseWord.dischargeDisable;
        end else if (apbWrite && index == `BKRC_IDX_CONTROL) begin
            control_r <= pwdata[7:0];
        end
    end

    // Current limit and on/off-time control
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            limit_r <= `BKRC_RST_LIMIT;
            tmode_r <= 1'b0;
        end else if (loadPulse) begin
            limit_r <= fuseWord.currentLimit;
        end else if (apbWrite && index == `BKRC_IDX_LIMIT) begin
            limit_r <= pwdata[1:0];
            tmode_r <= pwdata[`BKRC_LIM_TMODE];
        end
    end

    // Third buck run code and scheme select: fuse only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            thirdVolt_r <= `BKRC_RST_VOLT4;
            schemeSel_r <= 1'b0;
        end else if (loadPulse) begin
            thirdVolt_r <= fuseWord.thirdVolt;
            schemeSel_r <= fuseWord.schemeSel;
        end
    end

    // Read multiplexer; unused bits stay zero
    always_comb begin
        readData = 32'h0000_0000;
        readMapped = isMapped(paddr);
        case (index)
            `BKRC_IDX_RUN_VOLT: readData[5:0] = runVolt_r;
            `BKRC_IDX_SLEEP_VOLT: readData[5:0] = sleepVolt_r;
            `BKRC_IDX_CONTROL: readData[7:0] = control_r;
            `BKRC_IDX_LIMIT: begin
                readData[1:0] = limit_r;
                readData[`BKRC_LIM_TMODE] = tmode_r;
            end
            `BKRC_IDX_THIRD_VOLT: readData[3:0] = thirdVolt_r;
            `BKRC_IDX_STATUS: begin
                readData[0] = loadDone;
                readData[1] = schemeSel_r;
                readData[2] = (sleepVolt_r == runVolt_r);
            end
            default: readData = 32'h0000_0000;
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            prdata <= (readMapped && !pwrite) ? readData : 32'h0000_0000;
            pslverr <= !readMapped;
        end
    end

    // Converter controls follow the registers and the mode
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            buckTwoOn <= 1'b0;
            lowPowerActive <= 1'b0;
            targetVoltageCode <= 6'h00;
        end else begin
            case (mode)
                BKRC_MODE_RUN: begin
                    buckTwoOn <= control_r[`BKRC_CTL_RUN_EN];
                    lowPowerActive <= 1'b0;
                    targetVoltageCode <= runVolt_r;
                end
                BKRC_MODE_STANDBY: begin
                    buckTwoOn <= control_r[`BKRC_CTL_STBY_EN];
                    lowPowerActive <= control_r[`BKRC_CTL_LOW_PWR];
                    targetVoltageCode <= runVolt_r;
                end
                BKRC_MODE_SLEEP: begin
                    buckTwoOn <= control_r[`BKRC_CTL_SLEEP_EN];
                    lowPowerActive <= control_r[`BKRC_CTL_LOW_PWR];
                    targetVoltageCode <= sleepVolt_r;
                end
                default: begin
                    buckTwoOn <= 1'b0;
                    lowPowerActive <= 1'b0;
                    targetVoltageCode <= runVolt_r;
                end
            endcase
        end
    end

    // Switching mode, slew and discharge controls
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            slewSlow <= 1'b0;
            forcedPwmWhileScaling <= 1'b0;
            forcedPwm <= 1'b0;
            dischargeConnect <= 1'b0;
            currentLimitCode <= 2'h0;
            toffControl <= 1'b0;
            thirdRunVoltageCode <= 4'h0;
        end else begin
            slewSlow <= control_r[`BKRC_CTL_SLEW] && !schemeSel_r;
            forcedPwmWhileScaling <= control_r[`BKRC_CTL_FPWM_DVS];
            forcedPwm <= control_r[`BKRC_CTL_FPWM];
            dischargeConnect <= !control_r[`BKRC_CTL_DIS_OFF] && !buckTwoOn;
            currentLimitCode <= limit_r;
            toffControl <= tmode_r;
            thirdRunVoltageCode <= thirdVolt_r;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sleep_read_width_a: assert property (
        apbSetup && !pwrite && index == `BKRC_IDX_SLEEP_VOLT && paddr[1:0] == 2'h0
        |=> prdata[31:6] == 26'h0 && prdata[5:0] == $past(sleepVolt_r))
        else $error("sleep voltage read wrong");
    sleep_run_match_a: assert property (
        loadPulse |=> sleepVolt_r == runVolt_r)
        else $error("sleep code differs from run code after load");
    fuse_load_control_a: assert property (
        loadPulse |=> control_r[`BKRC_CTL_RUN_EN] == $past(fuseWord.runEnable)
            && control_r[`BKRC_CTL_STBY_EN] == control_r[`BKRC_CTL_RUN_EN])
        else $error("fuse load of enables wrong");
    host_write_a: assert property (
        apbWrite && index == `BKRC_IDX_CONTROL && !loadPulse
        |=> control_r == $past(pwdata[7:0]))
        else $error("control write lost");
    mode_enable_a: assert property (
        mode == BKRC_MODE_SLEEP ##1 mode == BKRC_MODE_SLEEP
        |-> buckTwoOn == $past(control_r[`BKRC_CTL_SLEEP_EN]))
        else $error("sleep enable not applied");
    low_power_run_a: assert property (
        $past(mode) == BKRC_MODE_RUN |-> !lowPowerActive)
        else $error("low power active in run mode");
    slew_ignore_a: assert property (
        schemeSel_r |=> !slewSlow)
        else $error("slew select not ignored");
    discharge_ctl_a: assert property (
        control_r[`BKRC_CTL_DIS_OFF] |=> !dischargeConnect)
        else $error("discharge connected while disabled by bit");
    forced_pwm_a: assert property (
        ##1 forcedPwm == $past(control_r[`BKRC_CTL_FPWM]))
        else $error("forced pwm output wrong");
    third_ro_a: assert property (
        apbWrite && index == `BKRC_IDX_THIRD_VOLT && !loadPulse |=> $stable(thirdVolt_r))
        else $error("third run code changed by write");
    limit_path_a: assert property (
        ##2 currentLimitCode == $past(limit_r))
        else $error("current limit not forwarded");

    fuse_load_c: cover property (loadPulse);
    control_write_c: cover property (apbWrite && index == `BKRC_IDX_CONTROL);
    sleep_on_c: cover property (mode == BKRC_MODE_SLEEP && buckTwoOn);
    bad_addr_c: cover property (pready && pslverr);
endmodule : bkrc_regfile

// ### core/bkrc_regs.svh
// Offsets, field positions, reset values and timing counts of the buck register bank.
// Assumes an APB master with 32-bit data; each register index takes one word.
// What this block does
// - Second buck sleep voltage is a six-bit code; bits 7:6 unused.
// - Sleep voltage code loads the same fuse value as the run code.
// - Fuse-backed fields load from fuses at start-up; all but the third run code and scheme select then stay host read/write.
// - Control bit 0 enables run mode; fuse-loaded; clearing turns the converter off in run mode.
// - Control bit 1 enables standby; default follows fuse run enable.
// - Control bit 2 enables the converter in sleep mode.
// - Control bit 3 selects low-power operation in standby or sleep.
// - Control bit 4 picks slew: 0 is step per 2 us, 1 per 4 us.
// - Slew select is ignored when fuse scaling scheme select is one.
// - Control bit 5 forces continuous conduction while scaling voltage down.
// - Control bit 6 forces PWM continuous conduction regardless of load.
// - Control bit 7 governs the discharge resistor at the feedback node when disabled.
// - Two-bit current limit code selects 1.0, 1.2, 1.5, 2.0 A; 00 at reset, then loaded from the fuses.
// - Third buck run voltage is a four-bit fuse code, read-only.
// - Second buck run voltage is a six-bit fuse code in its own register.
// - Discharge bit zero connects the resistor when disabled; one leaves it open.
`ifndef BKRC_REGS_SVH
`define BKRC_REGS_SVH
// Register indices; byte address is four times the index
`define BKRC_IDX_RUN_VOLT 8'h38
`define BKRC_IDX_SLEEP_VOLT 8'h3A
`define BKRC_IDX_CONTROL 8'h3B
`define BKRC_IDX_LIMIT 8'h3C
`define BKRC_IDX_THIRD_VOLT 8'h3E
`define BKRC_IDX_STATUS 8'h3F
// Control field positions
`define BKRC_CTL_RUN_EN 0
`define BKRC_CTL_STBY_EN 1
`define BKRC_CTL_SLEEP_EN 2
`define BKRC_CTL_LOW_PWR 3
`define BKRC_CTL_SLEW 4
`define BKRC_CTL_FPWM_DVS 5
`define BKRC_CTL_FPWM 6
`define BKRC_CTL_DIS_OFF 7
`define BKRC_LIM_TMODE 4
// Reset values before the fuse load
`define BKRC_RST_VOLT6 6'h00
`define BKRC_RST_VOLT4 4'h0
`define BKRC_RST_CONTROL 8'h00
`define BKRC_RST_LIMIT 2'h0
// Timing: fuse settle time and clock period
`define BKRC_CLK_PS 4000
`define BKRC_FUSE_SETTLE_NS 100
`define BKRC_FUSE_SETTLE_CYC ((`BKRC_FUSE_SETTLE_NS * 1000 + `BKRC_CLK_PS - 1) / `BKRC_CLK_PS)
`endif

// ### core/bkrc_pkg.sv
// Types of the buck register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package bkrc_pkg;
    // Device power mode as seen on the mode pins
    typedef enum logic [1:0] {
        BKRC_MODE_RUN = 2'h0,
        BKRC_MODE_STANDBY = 2'h1,
        BKRC_MODE_SLEEP = 2'h2
    } bkrc_mode_t;
    // Fuse loader states, one-hot
    typedef enum logic [2:0] {
        BKRC_LD_IDLE = 3'h1,
        BKRC_LD_WAIT = 3'h2,
        BKRC_LD_DONE = 3'h4
    } bkrc_ld_state_t;
    // Fuse word layout
    typedef struct packed {
        logic schemeSel;
        logic [3:0] thirdVolt;
        logic [1:0] currentLimit;
        logic dischargeDisable;
        logic slewSelect;
        logic runEnable;
        logic [5:0] runVolt;
    } bkrc_fuse_t;
endpackage : bkrc_pkg

// ### core/bkrc_fuse_loader.sv
// Fuse capture: synchronises the fuse pins and issues one load pulse after reset.
// Assumes fuse pins are static once settled; they come from outside the clock domain.
`timescale 1ns/100ps
`include "bkrc_regs.svh"
module bkrc_fuse_loader
    import bkrc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fuse pins
    input wire logic [15:0] fusePins,
    // Captured fuse word and load strobe
    output bkrc_fuse_t fuseWord,
    output logic loadPulse,
    output logic loadDone
);
    localparam int unsigned SETTLE = `BKRC_FUSE_SETTLE_CYC;
    logic [15:0] fuseMeta_r;
    logic [15:0] fuseSync_r;
    logic [7:0] count_r;
    bkrc_ld_state_t state_r;

    // Two-flop synchroniser on the fuse pins
    always_ff @(posedge clock) begin
        fuseMeta_r <= fusePins;
        fuseSync_r <= fuseMeta_r;
    end

    // Wait for the settle time, then load once
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= BKRC_LD_IDLE;
            count_r <= 8'h00;
            loadPulse <= 1'b0;
        end else begin
            loadPulse <= 1'b0;
            case (state_r)
                BKRC_LD_IDLE: begin
                    count_r <= 8'h00;
                    state_r <= BKRC_LD_WAIT;
                end
                BKRC_LD_WAIT: begin
                    count_r <= count_r + 8'h01;
                    if (count_r == 8'(SETTLE - 1)) begin
                        loadPulse <= 1'b1;
                        state_r <= BKRC_LD_DONE;
                    end
                end
                BKRC_LD_DONE: state_r <= BKRC_LD_DONE;
                default: state_r <= BKRC_LD_IDLE;
            endcase
        end
    end

    // Fuse word re-registered from the synchroniser every cycle, sampled by the load
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fuseWord <= '0;
        end else begin
            fuseWord <= fuseSync_r;
        end
    end

    assign loadDone = (state_r == BKRC_LD_DONE);
endmodule : bkrc_fuse_loader

// ### tb/bkrc_regfile_bench.sv
// Self-checking bench of the buck register bank: register rows, converter outputs, resets.
// Assumes the bank is the only APB slave and the fuse pins are static between resets.
`timescale 1ns/100ps
`include "bkrc_regs.svh"
module bkrc_regfile_bench
    import bkrc_pkg::*;
;
    // Register row: access, address, write data, expected read data and error
    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdExp;
        logic err;
    } bkrc_tb_reg_row_t;
    // Output row: mode pins, control byte, expected flags and target code
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] ctrl;
        logic [5:0] flags;
        logic [5:0] tgt;
    } bkrc_tb_out_row_t;
    localparam logic [9:0] ADDR_RUN = 10'(`BKRC_IDX_RUN_VOLT * 4);
    localparam logic [9:0] ADDR_SLEEP = 10'(`BKRC_IDX_SLEEP_VOLT * 4);
    localparam logic [9:0] ADDR_CTRL = 10'(`BKRC_IDX_CONTROL * 4);
    localparam logic [9:0] ADDR_LIMIT = 10'(`BKRC_IDX_LIMIT * 4);
    localparam logic [9:0] ADDR_THIRD = 10'(`BKRC_IDX_THIRD_VOLT * 4);
    localparam logic [9:0] ADDR_STATUS = 10'(`BKRC_IDX_STATUS * 4);
    // Fuses: run code 2B, run enable, slow slew, limit 10, third code A; second set adds scheme
    localparam logic [15:0] FUSE_A = 16'h54EB;
    localparam logic [15:0] FUSE_B = 16'hD4EB;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rdWord;
    logic [15:0] fusePins, outPack;
    logic [1:0] powerModePins, currentLimitCode;
    logic buckTwoOn, lowPowerActive, slewSlow, forcedPwmWhileScaling, forcedPwm;
    logic dischargeConnect, toffControl, errBit;
    logic [5:0] targetVoltageCode;
    logic [3:0] thirdRunVoltageCode;
    int fails, n_tests;
    bkrc_tb_reg_row_t regRows [0:13];
    bkrc_tb_out_row_t outRows [0:7];

    bkrc_regfile u_bkrc_regfile (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fusePins(fusePins), .powerModePins(powerModePins), .buckTwoOn(buckTwoOn),
        .lowPowerActive(lowPowerActive), .targetVoltageCode(targetVoltageCode),
        .slewSlow(slewSlow), .forcedPwmWhileScaling(forcedPwmWhileScaling),
        .forcedPwm(forcedPwm), .dischargeConnect(dischargeConnect),
        .currentLimitCode(currentLimitCode), .toffControl(toffControl),
        .thirdRunVoltageCode(thirdRunVoltageCode)
    );

    // Converter controls packed for one comparison
    assign outPack = {1'h0, buckTwoOn, lowPowerActive, slewSlow, forcedPwmWhileScaling,
                      forcedPwm, dischargeConnect, targetVoltageCode, currentLimitCode, toffControl};

    // 250 MHz clock
    always #2 clock = ~clock;

    // One APB transfer; holds the request until pready is seen at a rising edge, giving up after 20 edges
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20) begin
            fails++;
            $display("[ERR] %0t no pready", $time);
        end
        rdWord = prdata;
        errBit = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Compare a register word
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // Compare output pins
    task automatic check_bits(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t pins got %h expected %h", $time, got, exp);
        end
    endtask : check_bits

    // Counts and verdict, then end of run
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge clock);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    // Main sequence
    initial begin
        regRows = '{
            '{1'h0, ADDR_RUN, 32'h0, 32'h2B, 1'h0},
            '{1'h0, ADDR_SLEEP, 32'h0, 32'h2B, 1'h0},
            '{1'h0, ADDR_CTRL, 32'h0, 32'h13, 1'h0},
            '{1'h0, ADDR_LIMIT, 32'h0, 32'h2, 1'h0},
            '{1'h0, ADDR_THIRD, 32'h0, 32'hA, 1'h0},
            '{1'h1, ADDR_SLEEP, 32'hFFFFFFFF, 32'h3F, 1'h0},
            '{1'h1, ADDR_SLEEP, 32'h15, 32'h15, 1'h0},
            '{1'h1, ADDR_CTRL, 32'hFFFFFF5A, 32'h5A, 1'h0},
            '{1'h1, ADDR_LIMIT, 32'hFFFFFFFF, 32'h13, 1'h0},
            '{1'h1, ADDR_LIMIT, 32'h11, 32'h11, 1'h0},
            '{1'h1, ADDR_THIRD, 32'h5, 32'hA, 1'h0},
            '{1'h1, 10'h100, 32'hFF, 32'h0, 1'h1},
            '{1'h1, ADDR_SLEEP + 10'h1, 32'hFF, 32'h0, 1'h1},
            '{1'h0, ADDR_SLEEP, 32'h0, 32'h15, 1'h0}};
        // Flags: on, low power, slow slew, pwm while scaling, pwm, discharge
        outRows = '{
            '{2'h0, 8'h01, 6'h20, 6'h2B},
            '{2'h0, 8'h00, 6'h01, 6'h2B},
            '{2'h0, 8'h80, 6'h00, 6'h2B},
            '{2'h1, 8'h0A, 6'h30, 6'h2B},
            '{2'h1, 8'h09, 6'h11, 6'h2B},
            '{2'h2, 8'h04, 6'h20, 6'h15},
            '{2'h2, 8'h0B, 6'h11, 6'h15},
            '{2'h0, 8'h78, 6'h0F, 6'h2B}};
        clock = 1'h0;
        reset_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 10'h0;
        pwdata = 32'h0;
        fusePins = FUSE_A;
        powerModePins = 2'h0;
        fails = 0;
        n_tests = 0;
        repeat (4) @(posedge clock);
        reset_n <= 1'h1;
        repeat (40) @(posedge clock);
        // Register rows: writes are read back
        foreach (regRows[i]) begin
            apb(regRows[i].wr, regRows[i].addr, regRows[i].wdata);
            if (regRows[i].wr) begin
                check_bits({15'h0, errBit}, {15'h0, regRows[i].err});
                apb(1'h0, regRows[i].addr, 32'h0);
            end
            check_word(rdWord, regRows[i].rdExp);
            check_bits({15'h0, errBit}, {15'h0, regRows[i].err});
        end
        check_bits({12'h0, thirdRunVoltageCode}, 16'h000A);
        // Output rows across power modes
        foreach (outRows[i]) begin
            apb(1'h1, ADDR_CTRL, {24'h0, outRows[i].ctrl});
            powerModePins <= outRows[i].mode;
            repeat (8) @(posedge clock);
            #1;
            check_bits(outPack, {1'h0, outRows[i].flags, outRows[i].tgt, 2'h1, 1'h1});
        end
        // Every current limit code
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, ADDR_LIMIT, 32'(c));
            apb(1'h0, ADDR_LIMIT, 32'h0);
            check_word(rdWord, 32'(c));
            #1;
            check_bits({14'h0, currentLimitCode}, 16'(c));
        end
        // Mode code 3 forces the converter and low power off; other controls still follow the register
        @(posedge clock);
        powerModePins <= 2'h3;
        repeat (8) @(posedge clock);
        #1;
        check_bits(outPack, {1'h0, 6'h0F, 6'h2B, 2'h3, 1'h0});
        // Reset in mid-run with the alternative scaling scheme fused
        @(posedge clock);
        reset_n <= 1'h0;
        fusePins <= FUSE_B;
        powerModePins <= 2'h0;
        repeat (4) @(posedge clock);
        reset_n <= 1'h1;
        repeat (40) @(posedge clock);
        apb(1'h0, ADDR_SLEEP, 32'h0);
        check_word(rdWord, 32'h2B);
        apb(1'h0, ADDR_STATUS, 32'h0);
        check_word(rdWord, 32'h7);
        apb(1'h1, ADDR_CTRL, 32'h11);
        apb(1'h0, ADDR_CTRL, 32'h0);
        check_word(rdWord, 32'h11);
        repeat (8) @(posedge clock);
        #1;
        check_bits(outPack, {1'h0, 6'h20, 6'h2B, 2'h2, 1'h0});
        print_verdict();
    end
endmodule : bkrc_regfile_bench
